// ==== hw/tick_rtc_defs.vh ====
// Constants for the slow tick counter with serial slave
`ifndef TICK_RTC_DEFS_VH
`define TICK_RTC_DEFS_VH

// Serial addresses
`define ADDR_WRITE 8'ha0
`define ADDR_READ 8'ha1

// Instruction bytes
`define OP_DIV_STOP 8'h11
`define OP_DIV_RUN 8'h10
`define OP_PWR_DOWN 8'h21
`define OP_PWR_UP 8'h20
`define OP_XO_ON 8'h31
`define OP_XO_OFF 8'h30
`define OP_FAST_ON 8'h41
`define OP_FAST_OFF 8'h40
`define OP_LOAD 8'h80

// Counter and byte layout
`define CNT_W 24
`define CNT_HI_MSB 23
`define CNT_HI_LSB 16
`define CNT_MID_MSB 15
`define CNT_MID_LSB 8
`define CNT_LO_MSB 7
`define CNT_LO_LSB 0
`define CNT_RESET 24'h000000
`define BITS_PER_BYTE 4'h8

// Timing, in seconds and crystal edges
`define XTAL_HZ 32768
`define TICK_NORM_S 32
`define TICK_FAST_S 1
// Crystal edges per tick: 32 s and 1 s at 32768 Hz
`define TICK_NORM_EDGES 21'h100000
`define TICK_FAST_EDGES 21'h008000
// One bit wider than 20: a full 32 s period is exactly 2 to the 20
`define DIV_W 21

`endif

// ==== hw/sync_stage.v ====
// Two flip-flop synchroniser for one asynchronous pin
`default_nettype none

module sync_stage #(
  parameter [0:0] RESET_VAL = 1'b1
) (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);

  reg meta_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule // sync_stage

`default_nettype wire

// ==== hw/tick_rtc.v ====
// Slow tick counter with two-wire serial slave and wake output
`include "tick_rtc_defs.vh"
`default_nettype none

module tick_rtc #(
  parameter [`DIV_W-1:0] TICK_EDGES = `TICK_NORM_EDGES,
  parameter [`DIV_W-1:0] FAST_EDGES = `TICK_FAST_EDGES
) (
  input wire clk,
  input wire rst,
  input wire xtal_clk,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg wake_n,
  output reg [`CNT_W-1:0] count,
  output reg halted,
  output reg powered_down,
  output reg xtal_out_on,
  output reg fast_on,
  output reg access_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire xtal_s;
  wire scl_s;
  wire sda_s;

  sync_stage #(.RESET_VAL(1'b0)) u_sync_xtal (
    .clk(clk),
    .rst(rst),
    .din(xtal_clk),
    .dout(xtal_s)
  );

  sync_stage #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk(clk),
    .rst(rst),
    .din(scl),
    .dout(scl_s)
  );

  sync_stage #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk(clk),
    .rst(rst),
    .din(sda_in),
    .dout(sda_s)
  );

  reg xtal_q_r;
  reg scl_q_r;
  reg sda_q_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      xtal_q_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      xtal_q_r <= xtal_s;
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  wire xtal_rise = xtal_s & ~xtal_q_r;
  wire scl_rise = scl_s & ~scl_q_r;
  wire scl_fall = ~scl_s & scl_q_r;
  wire start_cond = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire stop_cond = scl_s & scl_q_r & ~sda_q_r & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain

  reg [`DIV_W-1:0] div_r;
  reg tick_r;
  wire [`DIV_W-1:0] div_term = fast_on ? (FAST_EDGES - 1'b1) : (TICK_EDGES - 1'b1);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= {`DIV_W{1'b0}};
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (halted) begin
        div_r <= {`DIV_W{1'b0}};
      end else if (xtal_rise && !powered_down) begin
        if (div_r >= div_term) begin
          div_r <= {`DIV_W{1'b0}};
          tick_r <= 1'b1;
        end else begin
          div_r <= div_r + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, pending increment and wake pin

  reg pending_r;
  reg [2:0] ld_stb_r;
  reg [7:0] ld_byte_r;
  wire do_inc = pending_r & ~access_busy & ~(|ld_stb_r);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= `CNT_RESET;
      pending_r <= 1'b0;
      wake_n <= 1'b1;
    end else begin
      pending_r <= tick_r | (pending_r & ~do_inc);
      if (ld_stb_r[0]) begin
        count[`CNT_HI_MSB:`CNT_HI_LSB] <= ld_byte_r;
      end else if (ld_stb_r[1]) begin
        count[`CNT_MID_MSB:`CNT_MID_LSB] <= ld_byte_r;
      end else if (ld_stb_r[2]) begin
        count[`CNT_LO_MSB:`CNT_LO_LSB] <= ld_byte_r;
      end else if (do_inc) begin
        count <= count + 1'b1;
      end
      if (xtal_out_on) begin
        wake_n <= xtal_s;
      end else if (do_inc && !(|ld_stb_r)) begin
        wake_n <= 1'b0;
      // Low for about one crystal period
      end else if (xtal_rise || powered_down) begin
        wake_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_WR = 5'b00100;
  localparam [4:0] ST_RD = 5'b01000;
  localparam [4:0] ST_IGN = 5'b10000;

  reg [4:0] st_r;
  reg [3:0] bit_cnt_r;
  reg ack_half_r;
  reg [7:0] sh_r;
  reg [7:0] tx_r;
  reg [1:0] set_idx_r;
  reg [1:0] rd_idx_r;
  reg nack_r;

  // Next readout byte, cycling high, middle, low
  reg [7:0] rd_byte;
  always @* begin
    case (rd_idx_r)
      2'd1: rd_byte = count[`CNT_MID_MSB:`CNT_MID_LSB];
      2'd2: rd_byte = count[`CNT_LO_MSB:`CNT_LO_LSB];
      default: rd_byte = count[`CNT_HI_MSB:`CNT_HI_LSB];
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      ack_half_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      set_idx_r <= 2'd0;
      rd_idx_r <= 2'd0;
      nack_r <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      access_busy <= 1'b0;
      ld_stb_r <= 3'b000;
      ld_byte_r <= 8'h00;
      halted <= 1'b0;
      powered_down <= 1'b0;
      xtal_out_on <= 1'b0;
      fast_on <= 1'b0;
    end else begin
      ld_stb_r <= 3'b000;
      if (start_cond) begin
        st_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        ack_half_r <= 1'b0;
        set_idx_r <= 2'd0;
        sda_oe <= 1'b0;
        access_busy <= 1'b1;
      end else if (stop_cond) begin
        st_r <= ST_IDLE;
        set_idx_r <= 2'd0;
        sda_oe <= 1'b0;
        access_busy <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == ST_ADDR || st_r == ST_WR || st_r == ST_RD) begin
          if (bit_cnt_r < `BITS_PER_BYTE) begin
            sh_r <= {sh_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 1'b1;
          end else if (st_r == ST_RD) begin
            nack_r <= sda_s;
          end
        end
      end else if (scl_fall) begin
        if (st_r == ST_RD && bit_cnt_r < `BITS_PER_BYTE && bit_cnt_r != 4'h0) begin
          sda_out <= tx_r[6];
          tx_r <= {tx_r[6:0], 1'b0};
        end else if (bit_cnt_r == `BITS_PER_BYTE && !ack_half_r) begin
          ack_half_r <= 1'b1;
          if (st_r == ST_ADDR) begin
            if (sh_r == `ADDR_WRITE) begin
              st_r <= ST_WR;
              sda_oe <= 1'b1;
              sda_out <= 1'b0;
            end else if (sh_r == `ADDR_READ) begin
              st_r <= ST_RD;
              rd_idx_r <= 2'd0;
              nack_r <= 1'b0;
              sda_oe <= 1'b1;
              sda_out <= 1'b0;
            end else begin
              st_r <= ST_IGN;
            end
          end else if (st_r == ST_WR) begin
            sda_oe <= 1'b1;
            sda_out <= 1'b0;
            if (set_idx_r != 2'd0) begin
              ld_byte_r <= sh_r;
              ld_stb_r <= {set_idx_r == 2'd3, set_idx_r == 2'd2, set_idx_r == 2'd1};
              set_idx_r <= (set_idx_r == 2'd3) ? 2'd0 : set_idx_r + 1'b1;
            end else begin
              if (sh_r == `OP_DIV_STOP) begin
                halted <= 1'b1;
              end else if (sh_r == `OP_DIV_RUN) begin
                halted <= 1'b0;
              end else if (sh_r == `OP_PWR_DOWN) begin
                powered_down <= 1'b1;
              end else if (sh_r == `OP_PWR_UP) begin
                powered_down <= 1'b0;
              end else if (sh_r == `OP_XO_ON) begin
                xtal_out_on <= 1'b1;
              end else if (sh_r == `OP_XO_OFF) begin
                xtal_out_on <= 1'b0;
              end else if (sh_r == `OP_FAST_ON) begin
                fast_on <= 1'b1;
              end else if (sh_r == `OP_FAST_OFF) begin
                fast_on <= 1'b0;
              end else if (sh_r == `OP_LOAD) begin
                set_idx_r <= 2'd1;
              end
            end
          end else begin
            // Free the line for the master acknowledge
            sda_oe <= 1'b0;
          end
        end else if (bit_cnt_r == `BITS_PER_BYTE && ack_half_r) begin
          ack_half_r <= 1'b0;
          bit_cnt_r <= 4'h0;
          if (st_r == ST_RD) begin
            if (nack_r) begin
              st_r <= ST_IGN;
              sda_oe <= 1'b1;
              sda_out <= 1'b1;
            end else begin
              tx_r <= rd_byte;
              sda_out <= rd_byte[7];
              sda_oe <= 1'b1;
              rd_idx_r <= (rd_idx_r == 2'd2) ? 2'd0 : rd_idx_r + 1'b1;
            end
          end else begin
            sda_oe <= 1'b0;
          end
        end
      end
    end
  end

endmodule // tick_rtc

`default_nettype wire

// ==== hw/tick_rtc_dummy_placeholder.v ====
// Empty unit kept for compile order
`default_nettype none
`default_nettype wire

// ==== tb/tick_rtc_chk.sv ====
// Port checker for the tick counter
`include "tick_rtc_defs.vh"
`default_nettype none
module tick_rtc_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic xtal_clk,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wake_n,
  input wire logic [`CNT_W-1:0] count,
  input wire logic halted,
  input wire logic powered_down,
  input wire logic xtal_out_on,
  input wire logic fast_on,
  input wire logic access_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////
  property p_rst; $past(rst) |-> count == `CNT_RESET && !sda_oe && wake_n; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_ack; sda_oe && !sda_out |-> access_busy; endproperty
  a_ack: assert property (p_ack) else $error("low drive idle");
  property p_fall; sda_oe && $past(sda_oe) && $changed(sda_out) |-> !scl; endproperty
  a_fall: assert property (p_fall) else $error("data change high");
  property p_step;
    $fell(wake_n) && !xtal_out_on && !$past(xtal_out_on) |-> count == $past(count) + 24'h1;
  endproperty
  a_step: assert property (p_step) else $error("step size");
  property p_wake;
    $changed(count) && !access_busy && !$past(access_busy) |-> !wake_n || xtal_out_on;
  endproperty
  a_wake: assert property (p_wake) else $error("silent step");
  property p_halt;
    halted && $fell(wake_n) && !xtal_out_on |-> $past(access_busy, 2);
  endproperty
  a_halt: assert property (p_halt) else $error("tick halted");
  property p_pd;
    powered_down && $past(powered_down) && !xtal_out_on && !$past(access_busy, 2) |-> wake_n;
  endproperty
  a_pd: assert property (p_pd) else $error("wake in power down");
  property p_busy;
    access_busy && $past(access_busy) |-> !$fell(wake_n) || xtal_out_on;
  endproperty
  a_busy: assert property (p_busy) else $error("tick in access");
  property p_width; $fell(wake_n) && !xtal_out_on |-> ##[1:40] wake_n; endproperty
  a_width: assert property (p_width) else $error("pulse width");
  ////////////////
  c_tick: cover property ($fell(wake_n));
  c_ack: cover property (sda_oe && !sda_out);
  c_halt: cover property ($rose(halted));
endmodule // tick_rtc_chk
bind tick_rtc tick_rtc_chk tick_rtc_chk_i (.clk(clk), .rst(rst), .xtal_clk(xtal_clk),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wake_n(wake_n),
  .count(count), .halted(halted), .powered_down(powered_down), .xtal_out_on(xtal_out_on),
  .fast_on(fast_on), .access_busy(access_busy));
`default_nettype wire

// ==== tb/serial_master.sv ====
// Two-wire bus master model
`default_nettype none
module serial_master (
  input wire logic clk,
  input wire logic sda_out,
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_oe = 1'b1;
  logic m_d = 1'b1;
  logic last = 1'b1;
  initial scl = 1'b1;
  assign sda = (sda_oe | m_oe) ? ((sda_out | ~sda_oe) & (m_d | ~m_oe)) : ~last;
  // Undriven line shows the inverse of the last driven level, held steady
  always @(posedge clk) begin
    if (sda_oe | m_oe) begin
      last <= sda;
    end
  end
  task automatic hp;
    repeat (4) @(posedge clk);
  endtask
  task automatic start;
    m_oe <= 1'b1;
    m_d <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    m_d <= 1'b0;
    hp;
    scl <= 1'b0;
  endtask
  // Stop with clock high; every access ends with one
  task automatic stop;
    m_oe <= 1'b1;
    m_d <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    m_d <= 1'b1;
    hp;
  endtask
  task automatic bit_io(input logic b, output logic q);
    hp;
    m_d <= b;
    hp;
    scl <= 1'b1;
    hp;
    q = sda;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic rd, input logic mack,
      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      m_oe <= !rd;
      bit_io(d[i], q[i]);
    end
    m_oe <= rd;
    bit_io(mack, ack);
  endtask
endmodule // serial_master
`default_nettype wire

// ==== tb/tick_rtc_test.sv ====
// Bench for the tick counter
`include "tick_rtc_defs.vh"
`default_nettype none
module tick_rtc_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TE = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic xtal_clk = 1'b0;
  wire logic scl, sda, sda_out, sda_oe, wake_n, halted, powered_down, xtal_out_on;
  wire logic fast_on, access_busy;
  wire logic [`CNT_W-1:0] count;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] q;
  logic a;
  logic [11:0] rows [8] = '{12'h118, 12'h100, 12'h214, 12'h200, 12'h312, 12'h300,
    12'h411, 12'h400};
  tick_rtc #(.TICK_EDGES(21'h000010), .FAST_EDGES(21'h000004)) tick_rtc_i (.clk(clk),
    .rst(rst), .xtal_clk(xtal_clk), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wake_n(wake_n), .count(count), .halted(halted),
    .powered_down(powered_down), .xtal_out_on(xtal_out_on), .fast_on(fast_on),
    .access_busy(access_busy));
  serial_master serial_master_i (.clk(clk), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));
  initial forever #25 clk = ~clk;
  // Crystal free running, exactly 20 clock periods, edges locked to clock falling edges
  initial forever #500 xtal_clk = ~xtal_clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      give_verdict;
    end
  end
  ////////////////
  task automatic give_verdict;
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp_val(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    serial_master_i.xfer(d, 1'b0, 1'b0, q, a);
    cmp_val("ack", 24'h0, {23'h0, a});
  endtask
  task automatic wacc(input logic [7:0] b [$]);
    serial_master_i.start;
    wr(`ADDR_WRITE);
    foreach (b[i]) wr(b[i]);
    serial_master_i.stop;
  endtask
  // Sampled on falling edge, clear of updates
  task automatic wait_tick(output int k);
    logic [23:0] v;
    v = count;
    k = 0;
    while (count === v && k < 2000) begin
      @(negedge clk);
      k++;
    end
  endtask
  ////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_val("count", 24'h0, count);
    cmp_val("idle", 24'h2, {22'h0, wake_n, sda_oe});
    foreach (rows[i]) begin
      wacc('{rows[i][11:4]});
      cmp_val("mode", rows[i][3:0], {halted, powered_down, xtal_out_on, fast_on});
    end
    // Halt first so no pending tick lands after the load
    wacc('{`OP_DIV_STOP});
    wacc('{`OP_DIV_STOP, `OP_LOAD, 8'ha9, 8'h00, 8'h01, `OP_FAST_ON});
    cmp_val("load", 24'ha90001, count);
    cmp_val("mode", 24'h9, {halted, powered_down, xtal_out_on, fast_on});
    wacc('{`OP_FAST_OFF, `OP_LOAD, 8'h5c});
    cmp_val("part", 24'h5c0001, count);
    serial_master_i.start;
    serial_master_i.xfer(8'ha2, 1'b0, 1'b0, q, a);
    cmp_val("nack", 24'h1, {23'h0, a});
    serial_master_i.xfer(`OP_DIV_RUN, 1'b0, 1'b0, q, a);
    serial_master_i.stop;
    cmp_val("ignored", 24'h3, {22'h0, halted, a});
    serial_master_i.start;
    wr(`ADDR_READ);
    for (int i = 0; i < 4; i++) begin
      serial_master_i.xfer(8'hff, 1'b1, i == 3, q, a);
      cmp_val("rd", 24'h5c0001 >> (8 * (2 - i % 3)) & 24'hff, q);
    end
    repeat (6) @(posedge clk);
    cmp_val("nack_high", 24'h3, {22'h0, sda_oe, sda_out});
    serial_master_i.stop;
    wacc('{`OP_DIV_RUN});
    wait_tick(n);
    cmp_val("first", 24'h1, {23'h0, n > (TE - 3) * 20 && n < (TE + 1) * 20});
    cmp_val("tick", 24'h5c0002, count);
    cmp_val("wake", 24'h0, {23'h0, wake_n});
    wacc('{`OP_DIV_STOP});
    wacc('{`OP_LOAD, 8'hff, 8'hff, 8'hff, `OP_DIV_RUN});
    wait_tick(n);
    cmp_val("wrap", 24'h0, count);
    serial_master_i.start;
    wr(`ADDR_READ);
    serial_master_i.xfer(8'hff, 1'b1, 1'b0, q, a);
    // Held for exactly one full period on purpose
    repeat (TE * 20) @(posedge clk);
    cmp_val("frozen", 24'h0, count);
    cmp_val("busy", 24'h1, {23'h0, access_busy});
    serial_master_i.xfer(8'hff, 1'b1, 1'b1, q, a);
    serial_master_i.stop;
    repeat (4) @(posedge clk);
    cmp_val("held", 24'h1, count);
    give_verdict;
  end
endmodule // tick_rtc_test
`default_nettype wire
